// [common/sac_cfg.svh]
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH
// Behaviour
// - Module runs only once enable bit 15 is set, the last step.
// - Master starts shifting and receiving when both buffer words are written.
// - Mono select sends the low buffer word on both left and right slots.
// - Mono select writable only while disabled; acts only in audio mode.
// - Protocol field bits 9-8 writable only while disabled; acts only in audio mode.
// - In audio mode outside protocol 11, frame pulse width behaves as one.

// ****************************************
// Register byte offsets
// ****************************************
`define SAC_OFS_CTRL_LOW   8'h00
`define SAC_OFS_CTRL_HIGH  8'h04
`define SAC_OFS_CTRL_SEC   8'h08
`define SAC_OFS_STAT_LOW   8'h0C
`define SAC_OFS_BUF_LOW    8'h10
`define SAC_OFS_BUF_HIGH   8'h14
`define SAC_OFS_INT_MASK   8'h18
`define SAC_OFS_RX_LOW     8'h1C
`define SAC_OFS_RX_HIGH    8'h20

// ****************************************
// Field positions
// ****************************************
`define SAC_BIT_EN        15
`define SAC_BIT_CKE       8
`define SAC_BIT_SLAVE_SELECT_PIN_ENABLE      7
`define SAC_BIT_MASTER_ROLE_SELECT     5
`define SAC_BIT_SMP       9
`define SAC_BIT_CKP       6
`define SAC_BIT_ROV       6
`define SAC_BIT_DONE      0
`define SAC_BIT_BUSY      1
`define SAC_BIT_AUDIO_CODEC_MODE     15
`define SAC_BIT_MONO      11
`define SAC_BIT_MOD_HI    9
`define SAC_BIT_MOD_LO    8
`define SAC_BIT_FRMEN     7
`define SAC_BIT_FRMPW     3

// ****************************************
// Reset values and timing
// ****************************************
`define SAC_RST_WORD      16'h0000
`define SAC_MOD_PCM       2'h3
`define SAC_CLK_HALF_NS   64
`define SAC_CLK_PERIOD_NS 8
`define SAC_HALF_CYC      (`SAC_CLK_HALF_NS / `SAC_CLK_PERIOD_NS)
`define SAC_FRAME_BITS    6'h20
`endif

// [common/sac_pkg.sv]
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_LEAD = 2'b01,
    SAC_SHIFT = 2'b10
  } sac_state_t;
  typedef logic [15:0] sac_word_t;
endpackage

// [common/sac_sync_if.sv]
`timescale 1ns/1ps
interface sac_sync_if;
  logic [2:0] raw;
  logic [2:0] synced;
  modport owner (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

// [logic/sac_sync.sv]
`timescale 1ns/1ps
module sac_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin group
  sac_sync_if.sync pins
);
  import sac_pkg::*;
  logic [2:0] stage1_q;
  logic [2:0] stage2_q;

  // Two flip-flop synchroniser per pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_q <= 3'h0;
      stage2_q <= 3'h0;
    end else begin
      stage1_q <= pins.raw;
      stage2_q <= stage1_q;
    end
  end
  assign pins.synced = stage2_q;
endmodule

// [logic/sac_top.sv]
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "sac_cfg.svh"
module sac_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial clock pin
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  // Frame pin
  input wire logic frame_in,
  output logic frame_out,
  output logic frame_oe,
  // Data pins
  input wire logic sdi,
  output logic sdo,
  // Interrupt
  output logic irq
);
  import sac_pkg::*;

  // ****************************************
  // Registers and pin synchroniser
  // ****************************************
  sac_word_t ctrl_low_q, ctrl_high_q, ctrl_sec_q, buf_low_q, buf_high_q;
  sac_word_t rx_low_q, rx_high_q;
  logic [31:0] shift_q;
  logic [1:0] stat_q, mask_q;
  logic rov_q, full_q;
  logic wr_lo_q, wr_hi_q;
  sac_state_t state_q;
  logic [5:0] bits_q;
  logic [3:0] div_q;
  logic sck_q, frame_q, sck_prev_q, slot_q;
  logic done_ev;
  sac_sync_if pin_if();
  assign pin_if.raw = {sck_in, frame_in, sdi};
  sac_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(pin_if)
  );

  wire en = ctrl_low_q[`SAC_BIT_EN];
  wire master = ctrl_low_q[`SAC_BIT_MASTER_ROLE_SELECT];
  wire audio_codec_mode = ctrl_high_q[`SAC_BIT_AUDIO_CODEC_MODE];
  wire [1:0] amod = ctrl_high_q[`SAC_BIT_MOD_HI:`SAC_BIT_MOD_LO];
  wire mono = audio_codec_mode & ctrl_high_q[`SAC_BIT_MONO];
  wire framed = audio_codec_mode | ctrl_high_q[`SAC_BIT_FRMEN];
  wire pulse_w = (audio_codec_mode && amod != `SAC_MOD_PCM) | ctrl_high_q[`SAC_BIT_FRMPW];
  wire ss_honour = !master && ctrl_low_q[`SAC_BIT_SLAVE_SELECT_PIN_ENABLE];
  wire ckp = ctrl_low_q[`SAC_BIT_CKP];
  wire input_sample_phase = ctrl_low_q[`SAC_BIT_SMP];
  wire s_sck = pin_if.synced[2];
  wire s_frame = pin_if.synced[1];
  wire s_sdi = pin_if.synced[0];

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  wire do_wr = aw_q && w_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  function automatic sac_word_t merge(input sac_word_t old, input sac_word_t nw, input sac_word_t m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // Address and data capture in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata[15:0];
        wstrb_q <= s_axi_wstrb[1:0];
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > `SAC_OFS_RX_HIGH || awaddr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_low_q <= `SAC_RST_WORD;
      ctrl_high_q <= `SAC_RST_WORD;
      ctrl_sec_q <= `SAC_RST_WORD;
      mask_q <= 2'h0;
    end else if (do_wr) begin
      case (awaddr_q)
        `SAC_OFS_CTRL_LOW: ctrl_low_q <= merge(ctrl_low_q, wdata_q, wmask);
        `SAC_OFS_CTRL_HIGH: begin
          // Mono and protocol locked while enabled
          ctrl_high_q <= merge(ctrl_high_q, wdata_q,
            wmask & (en ? 16'hF4FF : 16'hFFFF));
        end
        `SAC_OFS_CTRL_SEC: ctrl_sec_q <= merge(ctrl_sec_q, wdata_q, wmask);
        `SAC_OFS_INT_MASK: mask_q <= wdata_q[1:0] & wmask[1:0];
        default: ;
      endcase
    end
  end

  // Transmit buffers and start strobes
  wire wr_bl = do_wr && awaddr_q == `SAC_OFS_BUF_LOW;
  wire wr_bh = do_wr && awaddr_q == `SAC_OFS_BUF_HIGH;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_low_q <= `SAC_RST_WORD;
      buf_high_q <= `SAC_RST_WORD;
      wr_lo_q <= 1'b0;
      wr_hi_q <= 1'b0;
    end else begin
      if (wr_bl) buf_low_q <= merge(buf_low_q, wdata_q, wmask);
      if (wr_bh) buf_high_q <= merge(buf_high_q, wdata_q, wmask);
      if (state_q == SAC_LEAD) begin
        wr_lo_q <= 1'b0;
        wr_hi_q <= 1'b0;
      end else begin
        wr_lo_q <= wr_lo_q | wr_bl;
        wr_hi_q <= wr_hi_q | wr_bh;
      end
    end
  end

  // Read data path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `SAC_OFS_CTRL_LOW: s_axi_rdata <= {16'h0000, ctrl_low_q};
        `SAC_OFS_CTRL_HIGH: s_axi_rdata <= {16'h0000, ctrl_high_q};
        `SAC_OFS_CTRL_SEC: s_axi_rdata <= {16'h0000, ctrl_sec_q};
        `SAC_OFS_STAT_LOW: s_axi_rdata <= {25'h0, rov_q, 4'h0, state_q != SAC_IDLE, stat_q[0]};
        `SAC_OFS_BUF_LOW: s_axi_rdata <= {16'h0000, buf_low_q};
        `SAC_OFS_BUF_HIGH: s_axi_rdata <= {16'h0000, buf_high_q};
        `SAC_OFS_INT_MASK: s_axi_rdata <= {30'h0, mask_q};
        `SAC_OFS_RX_LOW: s_axi_rdata <= {16'h0000, rx_low_q};
        `SAC_OFS_RX_HIGH: s_axi_rdata <= {16'h0000, rx_high_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  wire rd_rx = s_axi_arvalid && s_axi_arready && s_axi_araddr == `SAC_OFS_RX_HIGH;

  // ****************************************
  // Status and interrupt
  // ****************************************
  wire w1c = do_wr && awaddr_q == `SAC_OFS_STAT_LOW;
  wire ov_ev = done_ev && full_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 2'h0;
      rov_q <= 1'b0;
      full_q <= 1'b0;
    end else begin
      // Set wins over a same-cycle clear
      stat_q[0] <= done_ev | (stat_q[0] & ~(w1c & wdata_q[`SAC_BIT_DONE]));
      stat_q[1] <= ov_ev | (stat_q[1] & ~(w1c & wdata_q[`SAC_BIT_ROV - 5]));
      rov_q <= ov_ev | (rov_q & ~(w1c & wdata_q[`SAC_BIT_ROV]));
      full_q <= done_ev | (full_q & ~rd_rx);
    end
  end
  assign irq = |(stat_q & mask_q);

  // ****************************************
  // Serial engine
  // ****************************************
  wire start = en && master && wr_lo_q && wr_hi_q;
  wire edge_lead = (state_q == SAC_SHIFT) && (master ? (div_q == 4'h0 && sck_q == ckp)
                   : (s_sck ^ sck_prev_q) && (s_sck != ckp));
  wire edge_trail = (state_q == SAC_SHIFT) && (master ? (div_q == 4'h0 && sck_q != ckp)
                    : (s_sck ^ sck_prev_q) && (s_sck == ckp));
  wire slave_go = en && !master && (framed ? s_frame : 1'b1) && (!ss_honour || s_frame);
  wire [5:0] frame_len = pulse_w ? 6'h10 : 6'h01;
  assign done_ev = edge_trail && bits_q == `SAC_FRAME_BITS - 6'h01;

  // Shift state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= SAC_IDLE;
      bits_q <= 6'h00;
      shift_q <= 32'h0000_0000;
      slot_q <= 1'b0;
    end else if (!en) begin
      state_q <= SAC_IDLE;
      bits_q <= 6'h00;
    end else begin
      case (state_q)
        SAC_IDLE: begin
          if (start || slave_go) begin
            state_q <= SAC_LEAD;
          end
        end
        SAC_LEAD: begin
          state_q <= SAC_SHIFT;
          bits_q <= 6'h00;
          // Mono repeats the low word in the left slot
          shift_q <= mono ? {buf_low_q, buf_low_q} : {buf_high_q, buf_low_q};
        end
        SAC_SHIFT: begin
          if (edge_lead == input_sample_phase) begin
            shift_q <= shift_q; // hold until the sampling edge
          end
          if (edge_trail) begin
            shift_q <= {shift_q[30:0], s_sdi};
            bits_q <= bits_q + 6'h01;
            if (bits_q == 6'h0F) slot_q <= ~slot_q;
            if (done_ev) begin
              state_q <= SAC_IDLE;
              slot_q <= 1'b0;
            end
          end
        end
        default: state_q <= SAC_IDLE;
      endcase
    end
  end

  // Receive capture at end of word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_low_q <= 16'h0000;
      rx_high_q <= 16'h0000;
    end else if (done_ev) begin
      rx_high_q <= shift_q[30:15];
      rx_low_q <= {shift_q[14:0], s_sdi};
    end
  end

  // Clock divider and pin drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 4'h0;
      sck_q <= 1'b0;
      frame_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= s_sck;
      if (state_q == SAC_SHIFT && master) begin
        if (div_q == 4'h0) begin
          div_q <= 4'(`SAC_HALF_CYC - 1);
          sck_q <= ~sck_q;
        end else begin
          div_q <= div_q - 4'h1;
        end
      end else begin
        div_q <= 4'(`SAC_HALF_CYC - 1);
        sck_q <= ckp;
      end
      // Frame pulse: one clock or a full slot wide; in audio mode also high through the second slot
      frame_q <= framed && state_q == SAC_SHIFT && (bits_q < frame_len || (audio_codec_mode && slot_q));
    end
  end
  assign sck_out = sck_q;
  assign sck_oe = en && master;
  assign frame_out = frame_q;
  assign frame_oe = en && master && framed;
  assign sdo = shift_q[31];
endmodule

// [sim/sac_properties.sv]
`timescale 1ns/1ps
module sac_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic frame_oe,
  input wire logic irq
);
  logic [7:0] aw_q;
  logic [15:0] w_q;
  logic en_q;
  logic ms_q;
  logic go_q;
  logic wdone;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Finished write
  assign wdone = s_axi_bvalid && s_axi_bready;
  // Shadow of taken address and data
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[15:0];
  end
  // Shadow of enable and role, plus buffer high write pulse
  always_ff @(posedge aclk) begin
    go_q <= aresetn && wdone && aw_q == 8'h14;
    if (!aresetn) begin
      en_q <= 1'b0;
      ms_q <= 1'b0;
    end else if (wdone && aw_q == 8'h00) begin
      en_q <= w_q[15];
      ms_q <= w_q[5];
    end
  end
  // ********
  // Checks
  // ********
  chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  chk_oe_enable: assert property (!s_axi_bvalid |-> sck_oe == (en_q && ms_q))
    else $error("clock drive disagrees with enable");
  chk_frame_dir: assert property (frame_oe |-> sck_oe)
    else $error("frame driven without clock");
  chk_shift_start: assert property (go_q && en_q && ms_q |-> ##[1:40] $changed(sck_out))
    else $error("transfer did not start");
  chk_reset_quiet: assert property ($rose(aresetn) |-> !irq && !sck_oe && !s_axi_bvalid)
    else $error("outputs active after reset");
endmodule
bind sac_top sac_properties i_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .sck_out(sck_out),
  .sck_oe(sck_oe),
  .frame_oe(frame_oe),
  .irq(irq)
);

// [sim/sac_partner.sv]
`timescale 1ns/1ps
module sac_partner (
  // Serial pins
  input wire logic sck,
  input wire logic oe,
  input wire logic sdo,
  output logic sdi,
  // Own link clock and select, for the block in slave role
  input wire logic run,
  output logic m_sck,
  output logic m_sel,
  // Words
  input wire logic [31:0] tx,
  output logic [31:0] rx
);
  logic [4:0] n;
  wire lclk;
  // Clock seen by the model: the block's when it is master, else our own
  assign lclk = oe ? sck : m_sck;
  // Idle start
  initial begin
    n = 5'h00;
    rx = 32'h0;
    sdi = 1'b0;
    m_sck = 1'b0;
    m_sel = 1'b0;
  end
  // Take block data and reply, msb first, both on the leading edge
  always @(posedge lclk) begin
    if (oe || m_sel) begin
      rx <= {rx[30:0], sdo};
      sdi <= tx[5'd31 - n];
      n <= n + 5'h01;
    end
  end
  // One 32-bit frame at a 125 ns period; clock idles low outside it
  always @(posedge run) begin
    m_sel = 1'b1;
    #100;
    repeat (31) begin
      m_sck = 1'b1;
      #62.5;
      m_sck = 1'b0;
      #62.5;
    end
    m_sck = 1'b1;
    #62.5;
    m_sck = 1'b0;
    m_sel = 1'b0;
    #62.5;
    sdi <= ~sdi;
  end
  // Released line shows the inverse level
  always @(negedge oe) begin
    sdi <= ~sdi;
    n <= 5'h00;
  end
endmodule

// [sim/test_spi_master_slave_audio_control.sv]
`timescale 1ns/1ps
module test_spi_master_slave_audio_control;
  logic aclk;
  logic aresetn;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdv, prx, ptx, v;
  logic [1:0] br, rrs;
  logic awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry, irq, sck, soe, fo, foe, sdo, sdi;
  logic msck, msel, prun;
  int n_errors, checks_done, fh, f0;
  sac_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdv), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .sck_in(soe ? sck : msck), .sck_out(sck), .sck_oe(soe), .frame_in(foe ? fo : msel), .frame_out(fo),
    .frame_oe(foe), .sdi(sdi), .sdo(sdo), .irq(irq));
  sac_partner i_far (.sck(sck), .oe(soe), .sdo(sdo), .sdi(sdi), .run(prun), .m_sck(msck), .m_sel(msel),
    .tx(ptx), .rx(prx));
  // ********
  // Tasks
  // ********
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    bry <= 1'b0;
    chk({30'h0, br}, {30'h0, a > 8'h20 ? 2'h2 : 2'h0});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rry <= 1'b0;
    chk(rdv, e);
    chk({30'h0, rrs}, {30'h0, a > 8'h20 ? 2'h2 : 2'h0});
  endtask
  // One word out and back, then mask and clear the done event
  task xfer(input logic [15:0] lo, input logic [15:0] hi, input logic mono, input logic slv);
    int n;
    n = 0;
    fh = 0;
    ptx = $urandom;
    wr(8'h10, {16'h0, lo});
    wr(8'h14, {16'h0, hi});
    prun <= slv;
    while (!irq && n < 3000) begin
      @(posedge aclk);
      n++;
      fh += int'(fo);
    end
    prun <= 1'b0;
    chk({31'h0, irq}, 32'h1);
    chk(prx, mono ? {lo, lo} : {hi, lo});
    rd(8'h1C, {16'h0, ptx[15:0]});
    rd(8'h20, {16'h0, ptx[31:16]});
    wr(8'h18, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h18, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(8'h0C, 32'h1);
    chk({31'h0, irq}, 32'h0);
  endtask
  // Clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Watchdog
  initial begin
    #200000;
    n_errors++;
    end_sim;
  end
  // Main sequence
  initial begin
    {aresetn, awv, wv, bry, arv, rry, awa, ara, wd, ptx, prun} = '0;
    n_errors = 0;
    checks_done = 0;
    v = $urandom(32'hd52b);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h04, 32'h0);
    repeat (3) begin
      v = $urandom;
      wr(8'h04, {16'h0, v[15:0]});
      rd(8'h04, {16'h0, v[15:0]});
    end
    wr(8'h40, 32'h1);
    rd(8'h40, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h0C, 32'h40);
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h20);
    wr(8'h00, 32'h8020);
    xfer(16'h0001, 16'h8000, 1'b0, 1'b0);
    v = $urandom;
    xfer(v[15:0], v[31:16], 1'b0, 1'b0);
    wr(8'h04, 32'h0B00);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h20);
    wr(8'h04, 32'h8800);
    wr(8'h00, 32'h8020);
    chk({31'h0, foe}, 32'h1);
    xfer(v[31:16], v[15:0], 1'b1, 1'b0);
    f0 = fh;
    wr(8'h00, 32'h20);
    wr(8'h04, 32'h8808);
    wr(8'h00, 32'h8020);
    xfer(v[15:0], v[31:16], 1'b1, 1'b0);
    chk(32'(fh), 32'(f0));
    chk(32'(f0 > 255), 32'h1);
    // Slave role: buffers cleared first, the partner clocks the frame
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0);
    rd(8'h14, 32'h0);
    wr(8'h00, 32'h0180);
    wr(8'h0C, 32'h40);
    wr(8'h00, 32'h8180);
    chk({31'h0, soe}, 32'h0);
    v = $urandom;
    xfer(v[15:0], v[31:16], 1'b0, 1'b1);
    end_sim;
  end
endmodule
